// >>> adc_cfg.svh
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// apb byte offsets
`define OFS_CTRL_FIRST 8'h00
`define OFS_RESULT_HIGH 8'h04
`define OFS_RESULT_LOW 8'h08
`define OFS_INT_STATUS 8'h0c
`define OFS_INT_MASK 8'h10

// first control register field positions
`define BIT_START 7
`define BIT_BUSY 6
`define BIT_ENABLE 5
`define BIT_FORMAT 4
`define BIT_GAIN_LOW 3
`define BIT_CHAN_HI 2
`define BIT_CHAN_LO 0

// interrupt status and mask field positions
`define BIT_INT_DONE 0
`define BIT_INT_ABORT 1
`define INT_W 2

// reset values
`define RST_CTRL_FIRST 8'h00
`define RST_INT_MASK 2'h0
`define RST_RESULT 10'h000

// widths
`define RESULT_W 10
`define CHAN_W 3
`define INPUTS_N 4

`endif

// >>> adc_control_register_zero.sv
// How it works
// - Writing the start bit high and then low while the converter is enabled launches one conversion and raises the busy flag.
// - The busy flag falls back to zero as soon as the running conversion has finished.
// - The busy flag is bit 6, reads one during a conversion, and ignores software writes.
// - With format zero the high byte holds result bits 9..2 and the low byte bits 1..0.
// - With format one the high byte holds result bits 9..8 and the low byte bits 7..0.
// - The gain code takes its low bit from bit 3 here and its high bit from the second register.
// - Gain code 00 gives 1.6V, 01 gives 3.0V, 10 gives 4.0V and 11 gives 1.6V again.
// - Channel codes 000 to 011 route analog inputs zero to three to the converter.
// - Channel codes 100 to 111 connect no input, leaving the converter input floating.
// - While the converter is disabled both result bytes keep their contents.
// - Result byte bits unused by the selected format always read as zero.
// - Each finished conversion raises the completion request and, when unmasked, the interrupt line.
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg.svh"

module adc_control_register_zero
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // high gain bit held in the second control register
    input wire logic gain_select_high,
    // converter core
    output logic conv_power_en,
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [`RESULT_W-1:0] conv_data,
    // analog routing
    output logic [`INPUTS_N-1:0] channel_connect,
    output logic input_floating,
    output adc_pkg::ref_level_t gain_stage_reference_level,
    // completion and interrupt
    output logic conv_request,
    output logic irq
);

    // first control register fields
    logic start_q;
    logic converter_enable_q;
    logic result_format_select_q;
    logic gain_select_low_q;
    logic [`CHAN_W-1:0] external_channel_select_q;

    // interrupt registers
    logic [`INT_W-1:0] int_status_q;
    logic [`INT_W-1:0] int_status_d;
    logic [`INT_W-1:0] int_mask_q;
    logic [`INT_W-1:0] int_mask_d;
    logic [`INT_W-1:0] int_events;
    logic irq_q;

    // bus bookkeeping
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic err_d;
    logic setup_phase;
    logic wr_access;
    logic wr_byte0;

    // write strobes, one for each writable address
    logic ctrl_wr;
    logic status_wr;
    logic mask_wr;

    // sequencer outputs
    logic conversion_busy_flag;
    logic done_evt;
    logic abort_evt;
    logic [`RESULT_W-1:0] result;

    // formatted result bytes
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic [7:0] ctrl_read;

    // gain code and routing
    logic [1:0] gain_code;
    adc_pkg::ref_level_t ref_level_d;
    adc_pkg::ref_level_t ref_level_q;
    logic [`INPUTS_N-1:0] channel_d;
    logic [`INPUTS_N-1:0] channel_q;
    logic floating_q;

    // apb phases; all data lives in byte lane 0, so writes need pstrb[0]
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign wr_byte0 = wr_access && pstrb[0] && !err_q;

    // address decode of the writes, shared by every register below
    assign ctrl_wr = wr_byte0 && (paddr == `OFS_CTRL_FIRST);
    assign status_wr = wr_byte0 && (paddr == `OFS_INT_STATUS);
    assign mask_wr = wr_byte0 && (paddr == `OFS_INT_MASK);

    // start bit is a plain stored level; the sequencer watches its high-low walk
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            start_q <= 1'(`RST_CTRL_FIRST >> `BIT_START);
        else if (ctrl_wr)
            start_q <= pwdata[`BIT_START];
    end

    // converter enable, off after reset so the analog part draws no current
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            converter_enable_q <= 1'b0;
        else if (ctrl_wr)
            converter_enable_q <= pwdata[`BIT_ENABLE];
    end

    // data format select
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            result_format_select_q <= 1'b0;
        else if (ctrl_wr)
            result_format_select_q <= pwdata[`BIT_FORMAT];
    end

    // low half of the gain code
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            gain_select_low_q <= 1'b0;
        else if (ctrl_wr)
            gain_select_low_q <= pwdata[`BIT_GAIN_LOW];
    end

    // external channel select; bit 6 of the write is dropped, busy is not writable
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            external_channel_select_q <= `CHAN_W'(`RST_CTRL_FIRST);
        else if (ctrl_wr)
            external_channel_select_q <= pwdata[`BIT_CHAN_HI:`BIT_CHAN_LO];
    end

    // conversion sequencing and result capture
    conv_seq #(
        .RES_W(`RESULT_W)
    ) u_seq (
        .clk(clk),
        .arst_n(arst_n),
        .start_bit(start_q),
        .enable(converter_enable_q),
        .conv_done(conv_done),
        .conv_data(conv_data),
        .conv_start(conv_start),
        .busy(conversion_busy_flag),
        .done_evt(done_evt),
        .abort_evt(abort_evt),
        .result_q(result)
    );

    assign conv_power_en = converter_enable_q;

    // result byte layout; unused positions are forced to zero
    always_comb
    begin
        if (result_format_select_q)
        begin
            result_high_byte = {6'h00, result[9:8]};
            result_low_byte = result[7:0];
        end
        else
        begin
            result_high_byte = result[9:2];
            result_low_byte = {result[1:0], 6'h00};
        end
    end

    // control register as software sees it, live busy flag in bit 6
    always_comb
    begin
        ctrl_read = 8'h00;
        ctrl_read[`BIT_START] = start_q;
        ctrl_read[`BIT_BUSY] = conversion_busy_flag;
        ctrl_read[`BIT_ENABLE] = converter_enable_q;
        ctrl_read[`BIT_FORMAT] = result_format_select_q;
        ctrl_read[`BIT_GAIN_LOW] = gain_select_low_q;
        ctrl_read[`BIT_CHAN_HI:`BIT_CHAN_LO] = external_channel_select_q;
    end

    // gain code decode; the top code aliases the lowest level
    assign gain_code = {gain_select_high, gain_select_low_q};
    always_comb
    begin
        case (gain_code)
            2'h0: ref_level_d = adc_pkg::REF_1V6;
            2'h1: ref_level_d = adc_pkg::REF_3V0;
            2'h2: ref_level_d = adc_pkg::REF_4V0;
            2'h3: ref_level_d = adc_pkg::REF_1V6;
            default: ref_level_d = adc_pkg::REF_1V6;
        endcase
    end

    // channel decode; codes beyond the last input connect nothing
    always_comb
    begin
        channel_d = `INPUTS_N'(0);
        case (external_channel_select_q)
            3'h0: channel_d = 4'h1;
            3'h1: channel_d = 4'h2;
            3'h2: channel_d = 4'h4;
            3'h3: channel_d = 4'h8;
            default: channel_d = `INPUTS_N'(0);
        endcase
    end

    // routing and reference outputs from flops, so switches see no decode glitches
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ref_level_q <= adc_pkg::REF_1V6;
            channel_q <= 4'h1;
            floating_q <= 1'b0;
        end
        else
        begin
            ref_level_q <= ref_level_d;
            channel_q <= channel_d;
            floating_q <= (channel_d == `INPUTS_N'(0));
        end
    end

    assign gain_stage_reference_level = ref_level_q;
    assign channel_connect = channel_q;
    assign input_floating = floating_q;

    // sticky interrupt events
    always_comb
    begin
        int_events = `INT_W'(0);
        int_events[`BIT_INT_DONE] = done_evt;
        int_events[`BIT_INT_ABORT] = abort_evt;
    end

    // write one to clear; an event in the same cycle wins over the clear
    always_comb
    begin
        int_status_d = int_status_q;
        if (status_wr)
            int_status_d = int_status_q & ~pwdata[`INT_W-1:0];
        int_status_d = int_status_d | int_events;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            int_status_q <= `INT_W'(0);
        else
            int_status_q <= int_status_d;
    end

    // interrupt mask, one bit per status bit
    always_comb
    begin
        int_mask_d = int_mask_q;
        if (mask_wr)
            int_mask_d = pwdata[`INT_W-1:0];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            int_mask_q <= `RST_INT_MASK;
        else
            int_mask_q <= int_mask_d;
    end

    // interrupt line from a flop fed by next status and mask: it moves on the same edge
    // as the status bit, yet a decode glitch can never reach the interrupt controller
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_q <= 1'b0;
        else
            irq_q <= |(int_status_d & int_mask_d);
    end

    // level interrupt and the completion pulse for the interrupt controller
    assign irq = irq_q;
    assign conv_request = done_evt;

    // read mux and error decode, evaluated in the setup cycle
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        case (paddr)
            `OFS_CTRL_FIRST:
                rdata_d[7:0] = ctrl_read;
            `OFS_RESULT_HIGH:
            begin
                rdata_d[7:0] = result_high_byte;
                err_d = pwrite; // result bytes are read only
            end
            `OFS_RESULT_LOW:
            begin
                rdata_d[7:0] = result_low_byte;
                err_d = pwrite;
            end
            `OFS_INT_STATUS:
                rdata_d[`INT_W-1:0] = int_status_q;
            `OFS_INT_MASK:
                rdata_d[`INT_W-1:0] = int_mask_q;
            default:
                err_d = 1'b1;
        endcase
    end

    // read data and error are captured at setup so the access phase shows stable flops;
    // the trade is that a read reflects state one cycle before the access edge
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end
        else if (setup_phase)
        begin
            rdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            err_q <= err_d;
        end
    end

    // every access completes in its first access cycle
    assign pready = psel && penable;
    assign pslverr = psel && penable && err_q;
    assign prdata = rdata_q;

endmodule
`default_nettype wire

// >>> adc_control_register_zero_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg.svh"
module adc_control_register_zero_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic gain_select_high = 1'b0;
    logic conv_done = 1'b0;
    logic [`RESULT_W-1:0] conv_data = 10'h000;
    logic [31:0] prdata;
    logic pready, pslverr, conv_power_en, conv_start, input_floating, conv_request, irq;
    logic [`INPUTS_N-1:0] channel_connect;
    adc_pkg::ref_level_t gain_stage_reference_level;
    logic [31:0] rdat;
    logic rerr;
    logic [9:0] d;
    logic [1:0] g;
    logic m;
    int bad_count = 0;
    int check_count = 0;
    int start_cnt = 0;
    int cyc = 0;
    int seed = 32'hb3c9;

    // system clock, 8 ns period
    always #4 clk = ~clk;

    adc_control_register_zero dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gain_select_high(gain_select_high), .conv_power_en(conv_power_en),
        .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
        .channel_connect(channel_connect), .input_floating(input_floating),
        .gain_stage_reference_level(gain_stage_reference_level), .conv_request(conv_request), .irq(irq));

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one apb transfer; no wait count assumed, the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one converter finish pulse carrying v
    task automatic finish_conv(input logic [9:0] v);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_data <= v;
        @(posedge clk);
        conv_done <= 1'b0;
    endtask

    function automatic logic [7:0] hi_exp(input logic [9:0] v, input logic f);
        return f ? {6'h00, v[9:8]} : v[9:2];
    endfunction

    function automatic logic [7:0] lo_exp(input logic [9:0] v, input logic f);
        return f ? v[7:0] : {v[1:0], 6'h00};
    endfunction

    // whole run is under two thousand cycles, so this leaves a wide margin
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            bad_count++;
            $display("Error at %0t: run timed out", $time);
            test_done;
        end
    end

    // converter start pulses counted mid-cycle, where the pulse has settled
    always @(negedge clk)
    begin
        if (conv_start === 1'b1)
            start_cnt <= start_cnt + 1;
    end

    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk(channel_connect, 4'h1, "reset route");
        chk(conv_power_en, 1'b0, "reset enable");
        apb(1'b0, `OFS_CTRL_FIRST, 32'h0);
        chk(rdat, 32'h0, "reset control");
        $display("test reset done");
        // every channel code under random gain codes, with a write to the busy bit thrown in
        for (int i = 0; i < 32; i++)
        begin
            g = 2'($random(seed));
            gain_select_high <= g[1];
            apb(1'b1, `OFS_CTRL_FIRST, {25'h0, i[3], 1'b0, i[4], g[0], i[2:0]});
            repeat (2) @(negedge clk);
            chk(channel_connect, i[2] ? 4'h0 : 4'h1 << i[1:0], "route");
            chk(input_floating, i[2], "floating");
            chk(gain_stage_reference_level, (g == 2'b11) ? 2'h0 : g, "reference");
            apb(1'b0, `OFS_CTRL_FIRST, 32'h0);
            chk(rdat, {27'h0, i[4], g[0], i[2:0]}, "control readback");
        end
        apb(1'b0, 8'h14, 32'h0);
        chk({rerr, rdat[30:0]}, 32'h80000000, "unmapped read");
        apb(1'b1, `OFS_CTRL_FIRST, 32'h80);
        apb(1'b1, `OFS_CTRL_FIRST, 32'h00);
        apb(1'b0, `OFS_CTRL_FIRST, 32'h0);
        chk(rdat, 32'h0, "start while disabled");
        $display("test routing done");
        for (int n = 0; n < 6; n++)
        begin
            d = 10'($random(seed));
            m = 1'($random(seed));
            if (n == 0)
                d = 10'h3ff;
            apb(1'b1, `OFS_INT_MASK, {31'h0, m});
            apb(1'b1, `OFS_CTRL_FIRST, 32'ha0);
            apb(1'b1, `OFS_CTRL_FIRST, 32'h20);
            apb(1'b0, `OFS_CTRL_FIRST, 32'h0);
            chk(rdat, 32'h60, "busy after start");
            chk(start_cnt, n + 1, "start pulses");
            finish_conv(d);
            @(negedge clk);
            chk(conv_request, 1'b1, "completion request");
            apb(1'b0, `OFS_CTRL_FIRST, 32'h0);
            chk(rdat, 32'h20, "busy after finish");
            chk(irq, m, "irq raised");
            apb(1'b0, `OFS_INT_STATUS, 32'h0);
            chk(rdat[0], 1'b1, "done status");
            for (int k = 0; k < 2; k++)
            begin
                apb(1'b1, `OFS_CTRL_FIRST, 32'h20 | (k << 4));
                apb(1'b0, `OFS_RESULT_HIGH, 32'h0);
                chk(rdat, hi_exp(d, k[0]), "high byte");
                apb(1'b0, `OFS_RESULT_LOW, 32'h0);
                chk(rdat, lo_exp(d, k[0]), "low byte");
            end
            apb(1'b1, `OFS_INT_STATUS, 32'h1);
            @(negedge clk);
            chk(irq, 1'b0, "irq cleared");
            apb(1'b1, `OFS_CTRL_FIRST, 32'h0);
            finish_conv(~d);
            apb(1'b0, `OFS_RESULT_HIGH, 32'h0);
            chk(rdat, hi_exp(d, 1'b0), "held while disabled");
        end
        // power pulled while busy with the finish pulse already on the wire: no result, abort flagged
        apb(1'b1, `OFS_CTRL_FIRST, 32'ha0);
        apb(1'b1, `OFS_CTRL_FIRST, 32'h20);
        apb(1'b1, `OFS_CTRL_FIRST, 32'h00);
        conv_done <= 1'b1;
        conv_data <= ~d;
        @(posedge clk);
        conv_done <= 1'b0;
        apb(1'b0, `OFS_CTRL_FIRST, 32'h0);
        chk(rdat, 32'h0, "busy after abort");
        apb(1'b0, `OFS_INT_STATUS, 32'h0);
        chk(rdat, 32'h2, "abort status");
        apb(1'b0, `OFS_RESULT_HIGH, 32'h0);
        chk(rdat, hi_exp(d, 1'b0), "held after abort");
        chk(start_cnt, 7, "abort start count");
        $display("test conversion done");
        test_done;
    end
endmodule
`default_nettype wire

// >>> adc_ctrl_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg.svh"
module adc_ctrl_chk
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    // converter, routing and reference
    input wire logic gain_select_high,
    input wire logic conv_power_en,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic [`INPUTS_N-1:0] channel_connect,
    input wire logic input_floating,
    input wire adc_pkg::ref_level_t gain_stage_reference_level,
    input wire logic conv_request
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // access phase of a control write that lands in the register
    sequence s_ctrl_wr;
        psel && penable && pwrite && pstrb[0] && paddr == `OFS_CTRL_FIRST;
    endsequence
    // gain high bit held still while the decode settles
    sequence s_gain_still;
        ##1 $stable(gain_select_high) ##1 $stable(gain_select_high);
    endsequence
    a_start_single_pulse: assert property (conv_start |=> !conv_start)
        else $error("converter start lasted more than one cycle");
    a_start_needs_power: assert property (conv_start |-> conv_power_en)
        else $error("converter started while disabled");
    a_request_from_done: assert property (conv_request |-> $past(conv_done))
        else $error("completion request without a finished conversion");
    a_request_single_pulse: assert property (conv_request |=> !conv_request)
        else $error("completion request lasted more than one cycle");
    a_floating_no_route: assert property (input_floating |-> channel_connect == '0)
        else $error("input routed while floating");
    a_route_one_hot: assert property (!input_floating |-> $onehot(channel_connect))
        else $error("route not one hot");
    a_float_after_write: assert property (s_ctrl_wr |-> ##2 input_floating == $past(pwdata[`BIT_CHAN_HI], 2))
        else $error("floating flag does not follow channel code");
    a_enable_after_write: assert property (s_ctrl_wr |=> conv_power_en == $past(pwdata[`BIT_ENABLE]))
        else $error("enable does not follow write");
    a_ref_after_write: assert property (s_ctrl_wr ##0 s_gain_still |->
        gain_stage_reference_level == ((gain_select_high ^ $past(pwdata[`BIT_GAIN_LOW], 2)) ?
        {gain_select_high, $past(pwdata[`BIT_GAIN_LOW], 2)} : 2'h0))
        else $error("reference level decode wrong");
    a_ready_zero_wait: assert property (psel && penable |-> pready)
        else $error("apb answer not in first access cycle");
endmodule
bind adc_control_register_zero adc_ctrl_chk chk_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .gain_select_high(gain_select_high), .conv_power_en(conv_power_en), .conv_start(conv_start),
    .conv_done(conv_done), .channel_connect(channel_connect), .input_floating(input_floating),
    .gain_stage_reference_level(gain_stage_reference_level), .conv_request(conv_request));
`default_nettype wire

// >>> adc_pkg.sv
`default_nettype none
package adc_pkg;

    // sequencer states, gray coded along idle-armed-busy-done
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ARMED = 2'b01,
        SEQ_BUSY = 2'b11,
        SEQ_DONE = 2'b10
    } seq_state_t;

    // level driven out of the gain stage reference
    typedef enum logic [1:0] {
        REF_1V6 = 2'b00,
        REF_3V0 = 2'b01,
        REF_4V0 = 2'b10
    } ref_level_t;

endpackage
`default_nettype wire

// >>> conv_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg.svh"

module conv_seq
#(
    parameter int RES_W = `RESULT_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control from the register file
    input wire logic start_bit,
    input wire logic enable,
    // converter handshake
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_data,
    output logic conv_start,
    // status back to the register file
    output logic busy,
    output logic done_evt,
    output logic abort_evt,
    output logic [RES_W-1:0] result_q
);

    adc_pkg::seq_state_t state_q;
    adc_pkg::seq_state_t state_d;
    logic start_q;
    logic abort_q;

    // next state: start level high then low launches a conversion
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            adc_pkg::SEQ_IDLE:
            begin
                if (enable && start_bit)
                    state_d = adc_pkg::SEQ_ARMED;
            end
            adc_pkg::SEQ_ARMED:
            begin
                if (!enable)
                    state_d = adc_pkg::SEQ_IDLE;
                else if (!start_bit)
                    state_d = adc_pkg::SEQ_BUSY;
            end
            adc_pkg::SEQ_BUSY:
            begin
                if (!enable)
                    state_d = adc_pkg::SEQ_IDLE;
                else if (conv_done)
                    state_d = adc_pkg::SEQ_DONE;
            end
            adc_pkg::SEQ_DONE:
                state_d = adc_pkg::SEQ_IDLE;
            default:
                state_d = adc_pkg::SEQ_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= adc_pkg::SEQ_IDLE;
        else
            state_q <= state_d;
    end

    // one-cycle start pulse on entry to busy
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            start_q <= 1'b0;
        else
            start_q <= (state_q == adc_pkg::SEQ_ARMED) && (state_d == adc_pkg::SEQ_BUSY);
    end

    // abort pulse when power is pulled mid-conversion
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            abort_q <= 1'b0;
        else
            abort_q <= (state_q == adc_pkg::SEQ_BUSY) && !enable;
    end

    // result is only taken while enabled, so a disabled converter leaves it alone
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            result_q <= RES_W'(`RST_RESULT);
        else if (state_q == adc_pkg::SEQ_BUSY && enable && conv_done)
            result_q <= conv_data;
    end

    assign conv_start = start_q;
    assign busy = (state_q == adc_pkg::SEQ_BUSY);
    assign done_evt = (state_q == adc_pkg::SEQ_DONE);
    assign abort_evt = abort_q;

endmodule
`default_nettype wire
